// ---- hw/dac_path_pkg.sv ----
// Constants shared by the transmit datapath: rate and modulation codes,
// carrier coefficients, output coding and buffer size.
// Assumes two's complement samples inside, offset binary at the core.
package dac_path_pkg;

    localparam int SAMPLE_W   = 16;
    localparam int FIFO_DEPTH = 4;

    // Interpolation rate field
    localparam logic [1:0] IR_1X = 2'h0;
    localparam logic [1:0] IR_2X = 2'h1;
    localparam logic [1:0] IR_4X = 2'h2;
    localparam logic [1:0] IR_8X = 2'h3;

    // Modulation select field
    localparam logic [1:0] MOD_OFF     = 2'h0;
    localparam logic [1:0] MOD_HALF    = 2'h1;
    localparam logic [1:0] MOD_QUARTER = 2'h2;
    localparam logic [1:0] MOD_EIGHTH  = 2'h3;

    // Carrier phase runs in eighths of a turn
    localparam logic [2:0] PH_STEP_HALF    = 3'h4;
    localparam logic [2:0] PH_STEP_QUARTER = 3'h2;
    localparam logic [2:0] PH_STEP_EIGHTH  = 3'h1;
    localparam logic [2:0] PH_STEP_NONE    = 3'h0;
    localparam logic [2:0] PH_COS_OFFSET   = 3'h2;

    localparam logic [15:0]        MIDSCALE        = 16'h8000;
    localparam logic signed [15:0] COEF_HALF_ROOT2 = 16'sh5A82;
    localparam int                 COEF_FRAC       = 15;
    localparam logic signed [18:0] SAT_MAX         = 19'sh07FFF;
    localparam logic signed [18:0] SAT_MIN         = 19'sh78000;

    typedef enum logic [2:0] {
        C_ZERO    = 3'h0,
        C_POS_H   = 3'h1,
        C_POS_ONE = 3'h3,
        C_NEG_H   = 3'h5,
        C_NEG_ONE = 3'h7
    } coef_t;

endpackage : dac_path_pkg

// ---- hw/sample_fifo.sv ----
// Small synchronous FIFO between the host sample port and the datapath.
// Assumes one clock; in_ready comes straight from a flip-flop.
`timescale 1ns/1ps
`default_nettype none
module sample_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [CW-1:0]    count_r;
    logic [CW-1:0]    count_nxt;
    logic             full_r;
    wire              push = in_valid && !full_r;
    wire              pop  = out_ready && (count_r != '0);

    assign in_ready  = !full_r;
    assign out_valid = (count_r != '0);
    assign out_data  = mem[rd_ptr_r];
    assign count_nxt = count_r + CW'(push) - CW'(pop);

    function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
        return (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
    endfunction : ptr_inc

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
            full_r   <= 1'b0;
        end
        else
        begin
            if (push)
            begin
                mem[wr_ptr_r] <= in_data;
                wr_ptr_r      <= ptr_inc(wr_ptr_r);
            end
            if (pop)
                rd_ptr_r <= ptr_inc(rd_ptr_r);
            count_r <= count_nxt;
            full_r  <= (count_nxt == CW'(DEPTH));
        end
    end
endmodule : sample_fifo
`default_nettype wire

// ---- hw/interp_stage.sv ----
// One channel of the interpolator: straight-line steps between samples.
// Stands in for the half-band chain; the coefficients are not modelled.
`timescale 1ns/1ps
`default_nettype none
module interp_stage #(
    parameter int W = 16
) (
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire logic                load,
    input  wire logic signed [W-1:0] din,
    input  wire logic [2:0]          step,
    input  wire logic [1:0]          rate_log2,
    output logic signed [W-1:0]      value
);
    logic signed [W-1:0] prev_r;
    logic signed [W-1:0] cur_r;
    wire  signed [W:0]   diff   = (W+1)'(cur_r) - (W+1)'(prev_r);
    wire  signed [W+4:0] scaled = (W+5)'(diff) * $signed({2'b00, step} + 5'h01);
    wire  signed [W+4:0] part   = scaled >>> rate_log2;

    // Reaches cur_r exactly on the last step, so the output never overshoots
    assign value = (rate_log2 == 2'h0) ? cur_r : W'((W+5)'(prev_r) + part);

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            prev_r <= '0;
            cur_r  <= '0;
        end
        else if (load)
        begin
            prev_r <= cur_r;
            cur_r  <= din;
        end
    end
endmodule : interp_stage
`default_nettype wire

// ---- hw/interp_modulator_datapath.sv ----
// Transmit datapath: sample FIFO, I/Q interpolation, digital modulator,
// zero stuffing, offset-binary output to the converter core.
// Assumes clk is the DAC sample clock and the control bits come from
// register logic in the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module interp_modulator_datapath
    import dac_path_pkg::*;
#(
    parameter int   DEPTH       = FIFO_DEPTH,
    parameter logic LAST_NEG    = 1'b0
) (
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    input  wire logic [1:0]                 interp_sel,
    input  wire logic [1:0]                 mod_sel,
    input  wire logic                       zero_stuff_en,
    input  wire logic                       complex_en,
    input  wire logic                       rot_pos,
    input  wire logic signed [SAMPLE_W-1:0] in_i,
    input  wire logic signed [SAMPLE_W-1:0] in_q,
    input  wire logic                       in_valid,
    output logic                            in_ready,
    output logic [SAMPLE_W-1:0]             dac_i,
    output logic [SAMPLE_W-1:0]             dac_q,
    output logic                            data_tick,
    output logic                            underrun
);
    // Carrier tables in eighths of a turn
    function automatic coef_t sine_code(input logic [2:0] idx);
        unique case (idx)
            3'h0:    return C_ZERO;
            3'h1:    return C_POS_H;
            3'h2:    return C_POS_ONE;
            3'h3:    return C_POS_H;
            3'h4:    return C_ZERO;
            3'h5:    return C_NEG_H;
            3'h6:    return C_NEG_ONE;
            3'h7:    return LAST_NEG ? C_NEG_H : C_POS_H;
        endcase
    endfunction : sine_code

    function automatic coef_t neg_code(input coef_t c);
        unique case (c)
            C_POS_H:   return C_NEG_H;
            C_NEG_H:   return C_POS_H;
            C_POS_ONE: return C_NEG_ONE;
            C_NEG_ONE: return C_POS_ONE;
            default:   return C_ZERO;
        endcase
    endfunction : neg_code

    function automatic logic signed [17:0] cmul(input logic signed [15:0] s,
                                                input coef_t c);
        logic signed [31:0] p;
        p = s * COEF_HALF_ROOT2;
        unique case (c)
            C_POS_ONE: return 18'(s);
            C_NEG_ONE: return -18'(s);
            C_POS_H:   return 18'(p >>> COEF_FRAC);
            C_NEG_H:   return -18'(p >>> COEF_FRAC);
            default:   return 18'sh00000;
        endcase
    endfunction : cmul

    function automatic logic signed [15:0] sat16(input logic signed [18:0] v);
        if (v > SAT_MAX)
            return 16'sh7FFF;
        else if (v < SAT_MIN)
            return 16'sh8000;
        else
            return v[15:0];
    endfunction : sat16

    function automatic logic [15:0] to_off(input logic signed [15:0] s);
        return s ^ MIDSCALE;
    endfunction : to_off

    function automatic logic [2:0] rate_mask(input logic [1:0] sel);
        unique case (sel)
            IR_1X: return 3'h0;
            IR_2X: return 3'h1;
            IR_4X: return 3'h3;
            IR_8X: return 3'h7;
        endcase
    endfunction : rate_mask

    logic [2:0]                 step_r;
    logic [2:0]                 step_nxt;
    logic [2:0]                 phase_r;
    logic [2:0]                 phase_nxt;
    logic                       stuff_r;
    logic                       stuff_nxt;
    logic [SAMPLE_W-1:0]        dac_i_r;
    logic [SAMPLE_W-1:0]        dac_q_r;
    logic                       data_tick_r;
    logic                       underrun_r;
    logic [2*SAMPLE_W-1:0]      fifo_data;
    logic                       fifo_valid;
    logic signed [SAMPLE_W-1:0] i_val;
    logic signed [SAMPLE_W-1:0] q_val;

    // Sequencing: one sample slot per DAC cycle, every other one when stuffing
    wire       slot      = !stuff_r;
    wire       step_last = (step_r == rate_mask(interp_sel));
    wire       pop       = slot && step_last;
    wire       load      = pop && fifo_valid;
    wire [2:0] ph_step   = (mod_sel == MOD_HALF)    ? PH_STEP_HALF :
                           (mod_sel == MOD_QUARTER) ? PH_STEP_QUARTER :
                           (mod_sel == MOD_EIGHTH)  ? PH_STEP_EIGHTH :
                                                      PH_STEP_NONE;

    assign stuff_nxt = zero_stuff_en && slot;
    assign step_nxt  = !slot ? step_r : (step_last ? 3'h0 : step_r + 3'h1);
    assign phase_nxt = slot ? phase_r + ph_step : phase_r;

    sample_fifo #(
        .WIDTH     (2 * SAMPLE_W),
        .DEPTH     (DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_data   ({in_i, in_q}),
        .in_valid  (in_valid),
        .in_ready  (in_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (pop)
    );

    // A missing sample holds the old pair; the converter keeps running
    interp_stage #(.W(SAMPLE_W)) u_interp_i (
        .clk       (clk),
        .rst_n     (rst_n),
        .load      (load),
        .din       (fifo_data[2*SAMPLE_W-1:SAMPLE_W]),
        .step      (step_r),
        .rate_log2 (interp_sel),
        .value     (i_val)
    );

    interp_stage #(.W(SAMPLE_W)) u_interp_q (
        .clk       (clk),
        .rst_n     (rst_n),
        .load      (load),
        .din       (fifo_data[SAMPLE_W-1:0]),
        .step      (step_r),
        .rate_log2 (interp_sel),
        .value     (q_val)
    );

    // Modulator works on interpolated values; no extra gain, so the real-mode
    // quarter/eighth images carry half amplitude as sine products do
    wire   cplx_on  = complex_en && (mod_sel == MOD_QUARTER
                                  || mod_sel == MOD_EIGHTH);
    wire   coef_t car_sin = sine_code(phase_r);
    wire   coef_t car_cos = sine_code(phase_r + PH_COS_OFFSET);
    wire   coef_t rot_sin = rot_pos ? car_sin : neg_code(car_sin);
    wire   coef_t car_re  = (mod_sel == MOD_OFF)  ? C_POS_ONE :
                            (mod_sel == MOD_HALF) ? car_cos : car_sin;

    wire signed [15:0] re_i = sat16(19'(cmul(i_val, car_re)));
    wire signed [15:0] re_q = sat16(19'(cmul(q_val, car_re)));
    wire signed [15:0] cx_i = sat16(19'(cmul(i_val, car_cos))
                                  - 19'(cmul(q_val, rot_sin)));
    wire signed [15:0] cx_q = sat16(19'(cmul(i_val, rot_sin))
                                  + 19'(cmul(q_val, car_cos)));
    wire [15:0] mod_i = to_off(cplx_on ? cx_i : re_i);
    wire [15:0] mod_q = to_off(cplx_on ? cx_q : re_q);

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            step_r      <= 3'h0;
            phase_r     <= 3'h0;
            stuff_r     <= 1'b0;
            dac_i_r     <= MIDSCALE;
            dac_q_r     <= MIDSCALE;
            data_tick_r <= 1'b0;
            underrun_r  <= 1'b0;
        end
        else
        begin
            step_r      <= step_nxt;
            phase_r     <= phase_nxt;
            stuff_r     <= stuff_nxt;
            dac_i_r     <= stuff_r ? MIDSCALE : mod_i;
            dac_q_r     <= stuff_r ? MIDSCALE : mod_q;
            data_tick_r <= pop;
            underrun_r  <= pop && !fifo_valid;
        end
    end

    assign dac_i     = dac_i_r;
    assign dac_q     = dac_q_r;
    assign data_tick = data_tick_r;
    assign underrun  = underrun_r;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    wire real_mode = !cplx_on;

    a_bypass_step: assert property (
        rst_n && interp_sel == IR_1X && !stuff_r && step_r == 3'h0 |=> data_tick)
        else $error("bypass rate did not take a sample every cycle");

    a_stuff_mid: assert property (
        stuff_r |=> dac_i_r == MIDSCALE && dac_q_r == MIDSCALE)
        else $error("stuffed slot not midscale");

    a_stuff_alt: assert property (
        rst_n && zero_stuff_en && slot ##1 zero_stuff_en |-> stuff_r ##1 !stuff_r)
        else $error("zero stuffing does not alternate");

    a_nomod_pass: assert property (
        slot && mod_sel == MOD_OFF && real_mode |=>
        dac_i_r == to_off($past(i_val)) && dac_q_r == to_off($past(q_val)))
        else $error("unmodulated path altered the interpolated sample");

    a_half_sign: assert property (
        slot && mod_sel == MOD_HALF && phase_r == 3'h4 |=>
        dac_i_r == to_off(sat16(-19'($past(i_val)))))
        else $error("half-rate carrier not negative on odd sample");

    a_half_unscaled: assert property (
        slot && mod_sel == MOD_HALF && phase_r == 3'h0 |=>
        dac_q_r == to_off($past(q_val)))
        else $error("half-rate carrier scaled the sample");

    a_quarter_zero: assert property (
        slot && mod_sel == MOD_QUARTER && real_mode && !phase_r[1] |=>
        dac_i_r == MIDSCALE && dac_q_r == MIDSCALE)
        else $error("quarter-rate zero coefficient not applied");

    a_eighth_peak: assert property (
        slot && mod_sel == MOD_EIGHTH && real_mode && phase_r == 3'h6 |=>
        dac_i_r == to_off(sat16(-19'($past(i_val)))))
        else $error("eighth-rate minus one coefficient wrong");

    a_cplx_rot_pos: assert property (
        slot && cplx_on && rot_pos && phase_r == 3'h2 |=>
        dac_i_r == to_off(sat16(-19'($past(q_val))))
        && dac_q_r == to_off($past(i_val)))
        else $error("positive rotation product wrong");

    a_cplx_rot_neg: assert property (
        slot && cplx_on && !rot_pos && phase_r == 3'h2 |=>
        dac_i_r == to_off($past(q_val))
        && dac_q_r == to_off(sat16(-19'($past(i_val)))))
        else $error("negative rotation product wrong");

    a_cplx_half_real: assert property (
        slot && complex_en && mod_sel == MOD_HALF && phase_r == 3'h0 |=>
        dac_q_r == to_off($past(q_val)))
        else $error("half rate coupled the channels");

    // Pacing, stuffing and carrier hold
    a_tick_2x: assert property (
        data_tick && !stuff_r && interp_sel == IR_2X && !zero_stuff_en
        ##1 interp_sel == IR_2X && !zero_stuff_en |-> !data_tick ##1 data_tick)
        else $error("2x rate did not take every other cycle");

    a_tick_stuff: assert property (
        rst_n && zero_stuff_en && pop |=> data_tick ##1 !data_tick)
        else $error("stuffed slot took a sample");

    a_stuff_hold: assert property (
        stuff_r |=> phase_r == $past(phase_r) && step_r == $past(step_r))
        else $error("stuffed slot advanced carrier or step");

    a_phase_off: assert property (
        mod_sel == MOD_OFF |=> phase_r == $past(phase_r))
        else $error("carrier moved with modulation off");

    a_under_tick: assert property (
        underrun_r |-> data_tick_r)
        else $error("underrun outside a sample request");

    // Carrier coefficients, one phase at a time
    a_half_neg_q: assert property (
        slot && mod_sel == MOD_HALF && phase_r == 3'h4 |=>
        dac_q_r == to_off(sat16(-19'($past(q_val)))))
        else $error("half-rate minus one scaled the sample");

    a_quarter_one: assert property (
        slot && mod_sel == MOD_QUARTER && real_mode && phase_r == 3'h2 |=>
        dac_i_r == to_off($past(i_val)) && dac_q_r == to_off($past(q_val)))
        else $error("quarter-rate plus one coefficient wrong");

    a_quarter_neg: assert property (
        slot && mod_sel == MOD_QUARTER && real_mode && phase_r == 3'h6 |=>
        dac_q_r == to_off(sat16(-19'($past(q_val)))))
        else $error("quarter-rate minus one coefficient wrong");

    a_eighth_one: assert property (
        slot && mod_sel == MOD_EIGHTH && real_mode && phase_r == 3'h2 |=>
        dac_q_r == to_off($past(q_val)))
        else $error("eighth-rate plus one coefficient wrong");

    a_eighth_zero: assert property (
        slot && mod_sel == MOD_EIGHTH && real_mode && phase_r == 3'h4 |=>
        dac_i_r == MIDSCALE && dac_q_r == MIDSCALE)
        else $error("eighth-rate zero coefficient wrong");

    a_cplx_unity: assert property (
        slot && cplx_on && phase_r == 3'h0 |=>
        dac_i_r == to_off($past(i_val)) && dac_q_r == to_off($past(q_val)))
        else $error("complex carrier not unity at phase zero");

    a_cplx_flip: assert property (
        slot && cplx_on && phase_r == 3'h4 |=>
        dac_i_r == to_off(sat16(-19'($past(i_val))))
        && dac_q_r == to_off(sat16(-19'($past(q_val)))))
        else $error("complex carrier not minus one at half turn");

    c_cplx_eighth: cover property (slot && cplx_on && mod_sel == MOD_EIGHTH);
    c_stuff_8x:    cover property (stuff_r && interp_sel == IR_8X);
    c_underrun:    cover property (underrun_r);
    c_fifo_full:   cover property (!in_ready ##1 data_tick);
    c_cplx_neg:    cover property (slot && cplx_on && !rot_pos);
endmodule : interp_modulator_datapath
`default_nettype wire

// ---- tb/host_source.sv ----
// Host side model: offers I/Q pairs on the valid/ready sample port.
// Assumes the bench supplies the pair values and the stall pattern.
`timescale 1ns/1ps
`default_nettype none
module host_source (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        en,
    input  wire logic        gap,
    input  wire logic [15:0] i_val,
    input  wire logic [15:0] q_val,
    input  wire logic        in_ready,
    output logic [15:0]      in_i,
    output logic [15:0]      in_q,
    output logic             in_valid
);
    initial
    begin
        in_i = 16'h0;
        in_q = 16'h0;
        in_valid = 1'b0;
    end

    // A pair once offered is held until taken; gap idles one cycle after a transfer
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            in_valid <= 1'b0;
        end
        else if (!in_valid || in_ready)
        begin
            if (en && !(gap && in_valid))
            begin
                in_valid <= 1'b1;
                in_i <= i_val;
                in_q <= q_val;
            end
            else
            begin
                // Released lines toggle so a stale value is never mistaken for data
                in_valid <= 1'b0;
                in_i <= ~in_i;
                in_q <= ~in_q;
            end
        end
    end
endmodule : host_source
`default_nettype wire

// ---- tb/interp_modulator_datapath_test.sv ----
// Self-checking bench for the transmit datapath: constant random pairs,
// carrier sequences found by phase search, stuffing, rate and buffer checks.
// Assumes dac_path_pkg and the host_source model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module interp_modulator_datapath_test;
    import dac_path_pkg::*;
    localparam int TOL = 2;
    logic                clk;
    logic                rst_n;
    logic [1:0]          interp_sel;
    logic [1:0]          mod_sel;
    logic                zero_stuff_en;
    logic                complex_en;
    logic                rot_pos;
    logic [15:0]         in_i;
    logic [15:0]         in_q;
    logic                in_valid;
    logic                in_ready;
    logic [SAMPLE_W-1:0] dac_i;
    logic [SAMPLE_W-1:0] dac_q;
    logic                data_tick;
    logic                underrun;
    logic                host_en;
    logic                host_gap;
    logic [15:0]         i_val;
    logic [15:0]         q_val;
    logic [31:0]         seed = 32'h75BFA157;
    int                  fail_count = 0;
    int                  compares = 0;
    int                  si[8];
    int                  sq[8];

    interp_modulator_datapath #(.DEPTH(FIFO_DEPTH), .LAST_NEG(1'b0)) i_dut (
        .clk(clk), .rst_n(rst_n), .interp_sel(interp_sel), .mod_sel(mod_sel),
        .zero_stuff_en(zero_stuff_en), .complex_en(complex_en), .rot_pos(rot_pos),
        .in_i(in_i), .in_q(in_q), .in_valid(in_valid), .in_ready(in_ready),
        .dac_i(dac_i), .dac_q(dac_q), .data_tick(data_tick), .underrun(underrun)
    );

    host_source i_host (
        .clk(clk), .rst_n(rst_n), .en(host_en), .gap(host_gap), .i_val(i_val),
        .q_val(q_val), .in_ready(in_ready), .in_i(in_i), .in_q(in_q), .in_valid(in_valid)
    );

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    function automatic logic [31:0] xorshift();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xorshift

    // Nonzero magnitude keeps stuffed slots distinguishable from data
    function automatic int rnd();
        int r;
        r = int'(xorshift() % 32'd15000) + 500;
        return xorshift() & 32'h1 ? r : -r;
    endfunction : rnd

    function automatic int sinq(input int idx);
        case (idx % 8)
            0, 4: return 0;
            1, 3, 7: return 23170;
            2: return 32768;
            5: return -23170;
            default: return -32768;
        endcase
    endfunction : sinq

    function automatic int exp_out(input int v, input int w, input int p, input logic is_q);
        int c;
        int s;
        c = (mod_sel == MOD_OFF) ? 32768 : (mod_sel == MOD_HALF) ? sinq(p + 2) : sinq(p);
        if (complex_en && mod_sel[1])
        begin
            c = sinq(p + 2);
            s = rot_pos ? sinq(p) : -sinq(p);
            return is_q ? (v * s + w * c) >>> 15 : (v * c - w * s) >>> 15;
        end
        return ((is_q ? w : v) * c) >>> 15;
    endfunction : exp_out

    function automatic logic near(input int a, input int b);
        return (a - b) <= TOL && (b - a) <= TOL;
    endfunction : near

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic finish_test();
        if (fail_count == 0 && compares > 0)
        begin
            $display("ALL TESTS PASSED");
        end
        else
        begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test

    task automatic apply_reset();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (10) @(posedge clk);
        @(negedge clk);
        check("reset_out", 32'h80008000, {dac_i, dac_q});
        check("reset_flags", 32'h1, {29'h0, data_tick, underrun, in_ready});
        @(posedge clk);
        rst_n <= 1'b1;
    endtask : apply_reset

    // Collects eight data slots; with stuffing every other slot must be midscale
    task automatic gather();
        logic [15:0] ri[16];
        logic [15:0] rq[16];
        int          par;
        for (int k = 0; k < 16; k++)
        begin
            @(negedge clk);
            ri[k] = dac_i ^ MIDSCALE;
            rq[k] = dac_q ^ MIDSCALE;
        end
        par = (zero_stuff_en && ri[0] === 16'h0) ? 1 : 0;
        for (int k = 0; k < 8; k++)
        begin
            if (zero_stuff_en)
            begin
                check("stuffed_i", 32'h0, {16'h0, ri[2 * k + 1 - par]});
                check("stuffed_q", 32'h0, {16'h0, rq[2 * k + 1 - par]});
            end
            si[k] = $signed(ri[zero_stuff_en ? 2 * k + par : k]);
            sq[k] = $signed(rq[zero_stuff_en ? 2 * k + par : k]);
        end
    endtask : gather

    task automatic run_case(input logic [1:0] ir, input logic [1:0] md, input logic zs,
                            input logic cx, input logic rp);
        int   v;
        int   w;
        int   n;
        int   stp;
        logic ok;
        logic hit;
        v = rnd();
        w = rnd();
        @(posedge clk);
        interp_sel <= ir;
        mod_sel <= md;
        zero_stuff_en <= zs;
        complex_en <= cx;
        rot_pos <= rp;
        i_val <= v[15:0];
        q_val <= w[15:0];
        host_en <= 1'b1;
        host_gap <= ^xorshift();
        apply_reset();
        repeat (150) @(posedge clk);
        for (int t = 0; t < 2; t++)
        begin
            n = 0;
            do begin @(negedge clk); n++; end while (data_tick !== 1'b1 && n < 200);
        end
        check("tick_period", (1 << ir) * (zs ? 2 : 1), n);
        gather();
        stp = (md == MOD_OFF) ? 0 : (md == MOD_HALF) ? 4 : (md == MOD_QUARTER) ? 2 : 1;
        hit = 1'b0;
        for (int p = 0; p < 8; p += (md == MOD_EIGHTH) ? 1 : 2)
        begin
            ok = 1'b1;
            for (int k = 0; k < 8; k++)
            begin
                if (!near(si[k], exp_out(v, w, p + k * stp, 1'b0)) ||
                    !near(sq[k], exp_out(v, w, p + k * stp, 1'b1)))
                    ok = 1'b0;
            end
            hit |= ok;
        end
        check("carrier", 32'h1, {31'h0, hit});
    endtask : run_case

    initial
    begin
        int n;
        int k;
        rst_n = 1'b0;
        interp_sel = IR_1X;
        mod_sel = MOD_OFF;
        zero_stuff_en = 1'b0;
        complex_en = 1'b0;
        rot_pos = 1'b0;
        host_en = 1'b0;
        host_gap = 1'b0;
        i_val = 16'h0;
        q_val = 16'h0;
        for (int ir = 0; ir < 4; ir++)
            for (int md = 0; md < 4; md++)
                run_case(ir[1:0], md[1:0], 1'b0, 1'b0, 1'b0);
        run_case(IR_1X, MOD_OFF, 1'b1, 1'b0, 1'b0);
        run_case(IR_2X, MOD_HALF, 1'b0, 1'b1, 1'b1);
        for (int rp = 0; rp < 2; rp++)
        begin
            run_case(2'(xorshift()), MOD_QUARTER, 1'b0, 1'b1, rp[0]);
            run_case(2'(xorshift()), MOD_EIGHTH, 1'b0, 1'b1, rp[0]);
        end
        run_case(IR_8X, MOD_HALF, 1'b1, 1'b0, 1'b0);
        // Slow drain at 8x stuffed lets a gap-free host fill the buffer
        @(posedge clk);
        host_gap <= 1'b0;
        n = 0;
        do begin @(negedge clk); n++; end while (in_ready !== 1'b0 && n < 100);
        check("fifo_full", 32'h0, {31'h0, in_ready});
        @(posedge clk);
        host_en <= 1'b0;
        n = 0;
        k = 0;
        do begin @(negedge clk); n++; k += data_tick; end while (underrun !== 1'b1 && n < 300);
        check("underrun", 32'h1, {31'h0, underrun});
        check("underrun_tick", 32'h1, {31'h0, data_tick});
        check("drained", 32'h1, {31'h0, k > FIFO_DEPTH});
        finish_test();
    end

    initial
    begin
        #800000;
        fail_count++;
        finish_test();
    end
endmodule : interp_modulator_datapath_test
`default_nettype wire
